//--- bench/dfhp_remote_model.sv
`timescale 1ns/1ps
// Behavioural second processor or peripheral on the remote port.
module dfhp_remote_model (
  input  wire logic       clock,
  input  wire logic [8:0] data_out,
  input  wire logic       data_oe,
  input  wire logic       rd_out,
  input  wire logic       rd_oe,
  input  wire logic       wr_out,
  input  wire logic       wr_oe,
  output logic            remote_clock,
  output logic      [8:0] data_in,
  output logic            rd_in,
  output logic            wr_in
);
  logic [8:0] pdrv   = 9'h000;
  logic       rd_drv = 1'b1;
  logic       wr_drv = 1'b1;
  logic [8:0] cap[$];
  // Strobes have pull-ups; a released data bus shows the inverted last byte.
  assign rd_in   = rd_oe ? rd_out : rd_drv;
  assign wr_in   = wr_oe ? wr_out : wr_drv;
  assign data_in = data_oe ? data_out : pdrv;
  // The timing clock is a plain input of the device, so it runs free.
  initial begin
    remote_clock = 1'b0;
    forever #20 remote_clock = ~remote_clock;
  end
  // collect bytes written under the device's own strobe.
  always @(negedge wr_in) begin
    @(posedge clock);
    #1 if (wr_oe && data_oe) cap.push_back(data_out);
  end
  // the second processor drives the strobes as inputs.
  task automatic put_byte(input logic [8:0] v);
    @(posedge clock);
    #1 pdrv = v;
    wr_drv = 1'b0;
    repeat (4) @(posedge clock);
    #1 wr_drv = 1'b1;
    repeat (4) @(posedge clock);
    #1 pdrv = ~v;
  endtask
  // Read strobe held long enough for the synchroniser to see it.
  task automatic get_byte(output logic [8:0] v);
    @(posedge clock);
    #1 rd_drv = 1'b0;
    repeat (6) @(posedge clock);
    #1 v = data_in;
    rd_drv = 1'b1;
    repeat (4) @(posedge clock);
  endtask
endmodule

//--- bench/dual_fifo_host_port_bypass_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench driving the host port and the remote model.
module dual_fifo_host_port_bypass_tb_top;
  logic        clock, reset_n, sel_n, stb_n, dir, a0, a1;
  logic        hoe, hrdy, rclk, rd_in, wr_in, rd_out, rd_oe;
  logic        wr_out, wr_oe, d_oe;
  logic [17:0] hdrv, hin, hout, q, ew;
  logic [8:0]  d_in, d_out, b;
  int          n_errors = 0, checked = 0, cycles = 0, n;
  // The host data wire carries the device value only while it drives.
  assign hin = hoe ? hout : hdrv;
  dfhp_top dut (.clock(clock), .reset_n(reset_n), .host_select_n(sel_n),
    .host_strobe_n(stb_n), .host_direction(dir), .resource_sel_lo(a0),
    .resource_sel_hi(a1), .host_data_in(hin), .host_data_out(hout),
    .host_data_oe(hoe), .host_fifo_ready(hrdy), .remote_clock(rclk),
    .remote_data_in(d_in), .remote_data_out(d_out), .remote_data_oe(d_oe),
    .remote_read_n_in(rd_in), .remote_read_n_out(rd_out),
    .remote_read_n_oe(rd_oe), .remote_write_n_in(wr_in),
    .remote_write_n_out(wr_out), .remote_write_n_oe(wr_oe));
  dfhp_remote_model partner (.clock(clock), .data_out(d_out),
    .data_oe(d_oe), .rd_out(rd_out), .rd_oe(rd_oe), .wr_out(wr_out),
    .wr_oe(wr_oe), .remote_clock(rclk), .data_in(d_in), .rd_in(rd_in),
    .wr_in(wr_in));
  // System clock at 100 MHz.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // A hang is cut short well beyond the expected run length.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Strobe low and high are each held past the synchroniser delay.
  task automatic hacc(input logic rw, input logic [1:0] res,
                      input logic [17:0] d, output logic [17:0] r);
    @(posedge clock);
    #1 sel_n = 1'b0;
    dir = rw;
    {a1, a0} = res;
    hdrv = d;
    stb_n = 1'b0;
    repeat (6) @(posedge clock);
    #1 r = hin;
    stb_n = 1'b1;
    repeat (4) @(posedge clock);
    #1 sel_n = 1'b1;
    hdrv = ~d;
  endtask
  task automatic wr(input logic [1:0] res, input logic [17:0] d);
    hacc(1'b0, res, d, q);
  endtask
  task automatic rd(input logic [1:0] res, input logic [17:0] e);
    hacc(1'b1, res, 18'h2aaaa, q);
    chk(q, e);
  endtask
  task automatic cfg(input logic [2:0] i, input logic w,
                     input logic [17:0] d);
    wr(dfhp_pkg::RES_CMD, {6'h00, dfhp_pkg::OPC_SEL_CFG, 5'h00, i});
    if (w)
      wr(dfhp_pkg::RES_CONFIG, d);
    else
      rd(dfhp_pkg::RES_CONFIG, d);
  endtask
  // Main sequence of host and remote transfers.
  initial begin
    {sel_n, stb_n, dir, a0, a1, hdrv, reset_n} = {2'h3, 22'h0};
    repeat (3) @(posedge clock);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge clock);
    cfg(dfhp_pkg::CFG_RESET4_IDX, 0, {2'h0, dfhp_pkg::CFG4_RESET});
    cfg(dfhp_pkg::CFG_MODE_IDX, 0, 18'h00000);
    cfg(dfhp_pkg::CFG_SPARE_IDX, 1, 18'h3abcd);
    cfg(dfhp_pkg::CFG_SPARE_IDX, 0, 18'h0abcd);
    // Strobes with select high must be ignored.
    @(posedge clock);
    #1 {dir, a1, a0, stb_n} = 4'hc;
    repeat (6) @(posedge clock);
    #1 chk({17'h0, hoe}, 18'h0);
    {dir, stb_n, hdrv} = {2'h0, 18'h01234};
    repeat (4) @(posedge clock);
    #1 stb_n = 1'b1;
    // Strobe stays high long enough before the next access.
    repeat (3) @(posedge clock);
    cfg(dfhp_pkg::CFG_SPARE_IDX, 0, 18'h0abcd);
    for (int i = 0; i < 17; i++)
      wr(dfhp_pkg::RES_FIFO, 18'h20000 ^ (18'(i) * 18'h01111));
    chk({17'h0, hrdy}, 18'h0);
    chk({16'h0, rd_oe, wr_oe}, 18'h0);
    partner.put_byte(9'h1a5);
    partner.put_byte(9'h03c);
    rd(dfhp_pkg::RES_FIFO, 18'h13ca5);
    rd(dfhp_pkg::RES_FIFO, 18'h00000);
    // Status in both formats: A to B full, B to A empty, odd byte a5.
    rd(dfhp_pkg::RES_CMD, 18'h006a5);
    wr(dfhp_pkg::RES_CMD, {6'h00, dfhp_pkg::OPC_STAT_FMT, 5'h00, 3'h1});
    rd(dfhp_pkg::RES_CMD, 18'h08606);
    for (int i = 0; i < 16; i++) begin
      ew = 18'h20000 ^ (18'(i) * 18'h01111);
      partner.get_byte(b);
      chk({9'h0, b}, {9'h0, ew[16], ew[7:0]});
      partner.get_byte(b);
      chk({9'h0, b}, {9'h0, ew[17], ew[15:8]});
    end
    chk({17'h0, hrdy}, 18'h1);
    cfg(dfhp_pkg::CFG_MODE_IDX, 1, 18'h00400);
    chk({16'h0, rd_oe, wr_oe}, 18'h3);
    wr(dfhp_pkg::RES_BYPASS, 18'h3fe55);
    repeat (40) @(posedge clock);
    chk({9'h0, partner.cap[$]}, 18'h00155);
    #1 partner.pdrv = 9'h1e7;
    rd(dfhp_pkg::RES_BYPASS, 18'h100e7);
    for (int c = 0; c < 4; c++) begin
      cfg(dfhp_pkg::CFG_MODE_IDX, 1, {5'h0, 2'(c), 11'h400});
      ew = (c == 2) ? 18'h0 : 18'h3;
      chk({16'h0, rd_oe, wr_oe}, ew);
      // The slave follows a full group of four master strobes.
      if (c == 2) repeat (4) partner.put_byte(9'h000);
    end
    cfg(dfhp_pkg::CFG_MODE_IDX, 1, 18'h00000);
    n = partner.cap.size();
    wr(dfhp_pkg::RES_BYPASS, 18'h000aa);
    repeat (40) @(posedge clock);
    chk(18'(partner.cap.size()), 18'(n));
    chk({16'h0, rd_oe, wr_oe}, 18'h0);
    close_out();
  end
endmodule

//--- hdl/dfhp_pkg.sv
package dfhp_pkg;
  // Word sizes of the host port, registers and remote port.
  localparam int WORD_W     = 18;
  localparam int REG_W      = 16;
  localparam int BYTE_W     = 9;
  localparam int FIFO_DEPTH = 16;
  localparam int CFG_COUNT  = 8;
  // Resource codes formed as {select high, select low}.
  localparam logic [1:0] RES_FIFO   = 2'h0;
  localparam logic [1:0] RES_BYPASS = 2'h1;
  localparam logic [1:0] RES_CONFIG = 2'h2;
  localparam logic [1:0] RES_CMD    = 2'h3;
  // Mode register location and its fields.
  localparam logic [2:0] CFG_MODE_IDX   = 3'h5;
  localparam logic [2:0] CFG_SPARE_IDX  = 3'h6;
  localparam logic [2:0] CFG_RESET4_IDX = 3'h4;
  localparam int         CASC_LSB       = 11;
  localparam int         CASC_MSB       = 12;
  localparam int         PERIPH_BIT     = 10;
  localparam logic [1:0] CASC_SLAVE     = 2'h2;
  localparam logic [1:0] CASC_MASTER    = 2'h3;
  localparam logic [15:0] CFG4_RESET    = 16'h6420;
  localparam logic [15:0] CFG_RESET     = 16'h0000;
  // Command word layout and opcodes.
  localparam int         OPC_LSB      = 8;
  localparam int         OPC_MSB      = 11;
  localparam int         OPR_MSB      = 2;
  localparam logic [3:0] OPC_RESET    = 4'h0;
  localparam logic [3:0] OPC_SEL_CFG  = 4'h1;
  localparam logic [3:0] OPC_DMA_DIR  = 4'h6;
  localparam logic [3:0] OPC_STAT_FMT = 4'h7;
  // Reset command operands.
  localparam logic [2:0] RST_BA   = 3'h1;
  localparam logic [2:0] RST_AB   = 3'h2;
  localparam logic [2:0] RST_BOTH = 3'h3;
  localparam logic [2:0] RST_ALL  = 3'h7;
  // Synchroniser reset values: host {sel_n, stb_n, dir, a1, a0}.
  localparam logic [4:0]  HCTL_IDLE = 5'h18;
  // Remote {clock, read_n, write_n, data[8:0]}.
  localparam logic [11:0] RPIN_IDLE = 12'h600;
endpackage

//--- hdl/dfhp_top.sv
`timescale 1ns/1ps
// Word FIFO with independent read and write pointers and a flush.
module dfhp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_ready & out_valid;

  // Pointers wrap at DEPTH so a depth that is not a power of two works.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage has no reset; only the pointers define its contents.
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// Operation
// - Two 18-bit FIFOs, one per direction, run at the same time.
// - Each FIFO owns separate read and write pointers.
// - Cascade field bits 12:11 of mode register; 00 means stand-alone.
// - Cascade value 10 makes a slave, 11 makes a master.
// - Slave handles first two remote bytes of four, master the next two.
// - Host processor controls everything; host control pins are inputs only.
// - Processor mode: remote control pins are inputs.
// - Peripheral mode: device drives remote control pins.
// - Stand-alone peripheral mode: every part drives its control pins.
// - Cascaded peripheral: master drives controls, slave takes inputs.
// - Select and address pins choose FIFO, bypass, config or command.
// - FIFO accesses move all 18 host bits including parity.
// - Bypass accesses use the low byte and its parity bit only.
// - Registers are 16 bits; parity bits play no part.
// - Bypass is a transceiver; remote controls are driven by the device.
// - Bypass is 9 bits per part; paired parts give 18.
// - Bypass only in peripheral mode, set by mode register bit 10; only bypass writes check it, bypass reads work in any mode.
// - Cascaded bypass write drives both remote buses together.
// - Cascaded bypass read returns each part's byte in its low lane.
// - Write data taken at strobe rise; read data shown from strobe fall.
// - Peripheral strobes are timed from the remote clock pin.
module dfhp_top #(
  parameter int WORD_W = dfhp_pkg::WORD_W,
  parameter int DEPTH  = dfhp_pkg::FIFO_DEPTH
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              host_select_n,
  input  wire logic              host_strobe_n,
  input  wire logic              host_direction,
  input  wire logic              resource_sel_lo,
  input  wire logic              resource_sel_hi,
  input  wire logic [WORD_W-1:0] host_data_in,
  output logic      [WORD_W-1:0] host_data_out,
  output logic                   host_data_oe,
  output logic                   host_fifo_ready,
  input  wire logic              remote_clock,
  input  wire logic [8:0]        remote_data_in,
  output logic      [8:0]        remote_data_out,
  output logic                   remote_data_oe,
  input  wire logic              remote_read_n_in,
  output logic                   remote_read_n_out,
  output logic                   remote_read_n_oe,
  input  wire logic              remote_write_n_in,
  output logic                   remote_write_n_out,
  output logic                   remote_write_n_oe
);
  typedef enum logic {DFHP_IDLE, DFHP_HOLD} dfhp_drv_t;

  logic [4:0]        hc_s1, hc_s2;
  logic [WORD_W-1:0] hd_s1, hd_s2;
  logic [11:0]       rp_s1, rp_s2;
  logic              stb_q, rclk_q, out_q, in_q;
  logic              sel_n, hdir, host_rd, host_wr, rclk_rise;
  logic [1:0]        res;
  logic [15:0]       cfg [dfhp_pkg::CFG_COUNT];
  logic [2:0]        cfg_sel;
  logic              dma_dir, stat_fmt;
  logic              periph, is_slave, is_master, cascaded, drive_ctl;
  logic              cmd_wr, flush_ab, flush_ba, sw_all;
  logic [3:0]        opc;
  logic [2:0]        opr;
  logic              ab_in_ready, ab_out_valid, ab_pop;
  logic [WORD_W-1:0] ab_out_data;
  logic              ba_in_ready, ba_out_valid, ba_push, ba_pop;
  logic [WORD_W-1:0] ba_out_data, ba_word;
  logic [15:0]       status;
  logic [8:0]        rbyte, odd_byte, byp_byte;
  logic              odd_valid, byp_pend;
  logic [1:0]        grp_out, grp_in;
  logic              turn_out, turn_in, out_n, in_n, out_end, in_end;
  logic              drv_rd_n, drv_wr_n;
  dfhp_drv_t         drv_state;

  // Every pin passes two flops; only the second stage is read by logic.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hc_s1 <= dfhp_pkg::HCTL_IDLE;
      hc_s2 <= dfhp_pkg::HCTL_IDLE;
      hd_s1 <= '0;
      hd_s2 <= '0;
      rp_s1 <= dfhp_pkg::RPIN_IDLE;
      rp_s2 <= dfhp_pkg::RPIN_IDLE;
    end else begin
      hc_s1 <= {host_select_n, host_strobe_n, host_direction,
                resource_sel_hi, resource_sel_lo};
      hc_s2 <= hc_s1;
      hd_s1 <= host_data_in;
      hd_s2 <= hd_s1;
      rp_s1 <= {remote_clock, remote_read_n_in, remote_write_n_in,
                remote_data_in};
      rp_s2 <= rp_s1;
    end
  end

  // Delayed copies for edge detection of the strobes and remote clock.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stb_q  <= 1'b1;
      rclk_q <= 1'b0;
      out_q  <= 1'b1;
      in_q   <= 1'b1;
    end else begin
      stb_q  <= hc_s2[3];
      rclk_q <= rp_s2[11];
      out_q  <= out_n;
      in_q   <= in_n;
    end
  end

  assign sel_n     = hc_s2[4];
  assign hdir      = hc_s2[2];
  assign res       = hc_s2[1:0];
  assign host_wr   = ~sel_n & ~stb_q & hc_s2[3] & ~hdir;
  assign host_rd   = ~sel_n & stb_q & ~hc_s2[3] & hdir;
  assign rclk_rise = rp_s2[11] & ~rclk_q;
  assign rbyte     = rp_s2[8:0];

  assign is_slave  = cfg[dfhp_pkg::CFG_MODE_IDX][dfhp_pkg::CASC_MSB:
                     dfhp_pkg::CASC_LSB] == dfhp_pkg::CASC_SLAVE;
  assign is_master = cfg[dfhp_pkg::CFG_MODE_IDX][dfhp_pkg::CASC_MSB:
                     dfhp_pkg::CASC_LSB] == dfhp_pkg::CASC_MASTER;
  assign cascaded  = is_slave | is_master;
  assign periph    = cfg[dfhp_pkg::CFG_MODE_IDX][dfhp_pkg::PERIPH_BIT];
  assign drive_ctl = periph & ~is_slave;

  // Command decode; operand and opcode share one host write.
  assign opc      = hd_s2[dfhp_pkg::OPC_MSB:dfhp_pkg::OPC_LSB];
  assign opr      = hd_s2[dfhp_pkg::OPR_MSB:0];
  assign cmd_wr   = host_wr & (res == dfhp_pkg::RES_CMD);
  assign sw_all   = cmd_wr & (opc == dfhp_pkg::OPC_RESET) &
                    (opr == dfhp_pkg::RST_ALL);
  assign flush_ab = sw_all | (cmd_wr & (opc == dfhp_pkg::OPC_RESET) &
                    ((opr == dfhp_pkg::RST_AB) | (opr == dfhp_pkg::RST_BOTH)));
  assign flush_ba = sw_all | (cmd_wr & (opc == dfhp_pkg::OPC_RESET) &
                    ((opr == dfhp_pkg::RST_BA) | (opr == dfhp_pkg::RST_BOTH)));

  // Register file; a software reset-all leaves the spare register alone.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < dfhp_pkg::CFG_COUNT; i++) begin
        cfg[i] <= (i == 4) ? dfhp_pkg::CFG4_RESET : dfhp_pkg::CFG_RESET;
      end
      cfg_sel <= '0;
    end else if (sw_all) begin
      for (int i = 0; i < dfhp_pkg::CFG_COUNT; i++) begin
        if (i != 6) begin
          cfg[i] <= (i == 4) ? dfhp_pkg::CFG4_RESET : dfhp_pkg::CFG_RESET;
        end
      end
    end else if (cmd_wr && opc == dfhp_pkg::OPC_SEL_CFG) begin
      cfg_sel <= opr;
    end else if (host_wr && res == dfhp_pkg::RES_CONFIG) begin
      cfg[cfg_sel] <= hd_s2[15:0];
    end
  end

  // Direction and status format survive software resets by design.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dma_dir  <= 1'b0;
      stat_fmt <= 1'b0;
    end else if (cmd_wr) begin
      if (opc == dfhp_pkg::OPC_DMA_DIR && periph) begin
        dma_dir <= opr[0];
      end
      if (opc == dfhp_pkg::OPC_STAT_FMT) begin
        stat_fmt <= opr[0];
      end
    end
  end

  dfhp_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_ab_fifo (
    .clock    (clock),
    .reset_n  (reset_n),
    .flush    (flush_ab),
    .in_valid (host_wr && res == dfhp_pkg::RES_FIFO),
    .in_ready (ab_in_ready),
    .in_data  (hd_s2),
    .out_valid(ab_out_valid),
    .out_ready(ab_pop),
    .out_data (ab_out_data)
  );
  dfhp_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_ba_fifo (
    .clock    (clock),
    .reset_n  (reset_n),
    .flush    (flush_ba),
    .in_valid (ba_push),
    .in_ready (ba_in_ready),
    .in_data  (ba_word),
    .out_valid(ba_out_valid),
    .out_ready(ba_pop),
    .out_data (ba_out_data)
  );
  assign host_fifo_ready = ab_in_ready;
  assign ba_pop = host_rd & (res == dfhp_pkg::RES_FIFO) & ba_out_valid;

  // Upper byte is common; the low byte depends on the status format.
  assign status = {stat_fmt, odd_valid, 2'h0, ~ab_out_valid, ~ab_in_ready,
                   ~ba_out_valid, ~ba_in_ready,
                   stat_fmt ? {3'h0, dma_dir, ~ab_out_valid, ~ab_in_ready,
                               ~ba_out_valid, ~ba_in_ready}
                            : odd_byte[7:0]};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      host_data_out <= '0;
    end else if (host_rd) begin
      case (res)
        dfhp_pkg::RES_FIFO:   host_data_out <= ba_out_valid ? ba_out_data : '0;
        dfhp_pkg::RES_BYPASS: host_data_out <= {1'b0, rbyte[8], 8'h00,
                                                rbyte[7:0]};
        dfhp_pkg::RES_CONFIG: host_data_out <= {2'h0, cfg[cfg_sel]};
        default:              host_data_out <= {2'h0, status};
      endcase
    end
  end

  // drive only while selected and strobed.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      host_data_oe <= 1'b0;
    end else begin
      host_data_oe <= host_rd | (host_data_oe & ~sel_n & ~hc_s2[3] & hdir);
    end
  end

  // bypass byte leaves through driven strobes.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      byp_pend <= 1'b0;
      byp_byte <= '0;
    end else if (host_wr && res == dfhp_pkg::RES_BYPASS && periph) begin
      byp_pend <= 1'b1;
      byp_byte <= {hd_s2[16], hd_s2[7:0]};
    end else if (out_end) begin
      byp_pend <= 1'b0;
    end
  end

  // peripheral strobes step on remote clock rises.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      drv_state <= DFHP_IDLE;
      drv_rd_n  <= 1'b1;
      drv_wr_n  <= 1'b1;
    end else if (!drive_ctl) begin
      drv_state <= DFHP_IDLE;
      drv_rd_n  <= 1'b1;
      drv_wr_n  <= 1'b1;
    end else if (rclk_rise) begin
      case (drv_state)
        DFHP_IDLE: begin
          if (byp_pend || (dma_dir && (ab_out_valid || !turn_out))) begin
            drv_wr_n  <= 1'b0;
            drv_state <= DFHP_HOLD;
          end else if (!dma_dir && ba_in_ready) begin
            drv_rd_n  <= 1'b0;
            drv_state <= DFHP_HOLD;
          end
        end
        DFHP_HOLD: begin
          drv_rd_n  <= 1'b1;
          drv_wr_n  <= 1'b1;
          drv_state <= DFHP_IDLE;
        end
        default: drv_state <= DFHP_IDLE;
      endcase
    end
  end

  // processor mode reads pins as inputs.
  assign out_n = drive_ctl ? drv_wr_n : (periph ? rp_s2[9] : rp_s2[10]);
  assign in_n  = drive_ctl ? drv_rd_n : (periph ? rp_s2[10] : rp_s2[9]);
  assign out_end = out_n & ~out_q;
  assign in_end  = in_n & ~in_q;
  assign remote_read_n_out  = drv_rd_n;
  assign remote_write_n_out = drv_wr_n;
  assign remote_read_n_oe   = drive_ctl;
  assign remote_write_n_oe  = drive_ctl;

  // slave owns bytes 0-1, master bytes 2-3.
  assign turn_out = ~cascaded | (is_slave ? ~grp_out[1] : grp_out[1]);
  assign turn_in  = ~cascaded | (is_slave ? ~grp_in[1] : grp_in[1]);

  // Byte counters run on every bus byte except bypass writes so both parts stay in step.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      grp_out <= '0;
    end else if (flush_ab) begin
      grp_out <= '0;
    end else if (out_end && !byp_pend) begin
      grp_out <= grp_out + 2'h1;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      grp_in <= '0;
    end else if (flush_ba) begin
      grp_in <= '0;
    end else if (in_end) begin
      grp_in <= grp_in + 2'h1;
    end
  end

  // A word leaves after its high byte; low byte first on the remote bus.
  assign ab_pop = out_end & ~byp_pend & turn_out & grp_out[0] & ab_out_valid;

  // each part carries 9 bits of bypass.
  // bypass byte driven regardless of turn.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      remote_data_out <= '0;
    end else if (byp_pend) begin
      remote_data_out <= byp_byte;
    end else begin
      remote_data_out <= grp_out[0] ? {ab_out_data[17], ab_out_data[15:8]}
                                    : {ab_out_data[16], ab_out_data[7:0]};
    end
  end
  assign remote_data_oe = ~out_n & (byp_pend | turn_out);

  // Odd byte holds the low half until its partner arrives.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      odd_byte  <= '0;
      odd_valid <= 1'b0;
    end else if (flush_ba) begin
      odd_valid <= 1'b0;
    end else if (in_end && turn_in) begin
      if (!grp_in[0]) begin
        odd_byte  <= rbyte;
        odd_valid <= 1'b1;
      end else begin
        odd_valid <= 1'b0;
      end
    end
  end
  // A full FIFO drops the word; peripheral mode never strobes then.
  assign ba_word = {rbyte[8], odd_byte[8], rbyte[7:0], odd_byte[7:0]};
  assign ba_push = in_end & turn_in & grp_in[0];

  default clocking dfhp_cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  chk_deselect_quiet: assert property (
    sel_n |=> !host_data_oe) else $error("Host data driven while deselected.");
  chk_read_drive: assert property (
    host_rd |=> host_data_oe [*1] ##0 !sel_n)
    else $error("Read data not presented after strobe fall.");
  chk_fifo_store: assert property (
    host_wr && res == dfhp_pkg::RES_FIFO && ab_in_ready && !flush_ab
    |=> ab_out_valid) else $error("Host FIFO write was not stored.");
  chk_slave_decode: assert property (
    host_wr && res == dfhp_pkg::RES_CONFIG && cfg_sel == 3'h5 &&
    hd_s2[12:11] == 2'h2 && !sw_all |=> is_slave && !is_master)
    else $error("Cascade 10 did not select slave.");
  chk_alone_decode: assert property (
    host_wr && res == dfhp_pkg::RES_CONFIG && cfg_sel == 3'h5 &&
    !hd_s2[12] && !sw_all |=> !cascaded)
    else $error("Cascade 0x did not select stand-alone.");
  chk_proc_inputs: assert property (
    !periph |-> !remote_read_n_oe && !remote_write_n_oe)
    else $error("Remote controls driven in processor mode.");
  chk_bypass_lane: assert property (
    host_rd && res == dfhp_pkg::RES_BYPASS
    |=> host_data_out[15:8] == 8'h00 && !host_data_out[17])
    else $error("Bypass read used lanes outside the low byte.");
  chk_reg_width: assert property (
    host_rd && res[1] |=> host_data_out[17:16] == 2'h0)
    else $error("Register read drove parity lanes.");
  chk_strobe_clock: assert property (
    $fell(drv_wr_n) || $fell(drv_rd_n) |-> $past(rclk_rise))
    else $error("Peripheral strobe not aligned to remote clock.");
  chk_slave_turn: assert property (
    is_slave && out_end && !byp_pend && grp_out[1] |-> !ab_pop)
    else $error("Slave consumed a master byte slot.");
endmodule
